// ==== logic/rtcb_top.sv ====
// rtcb_top: bcd time-of-day and calendar registers with alarm compare.
// assumes a word-addressed cpu port and the 32.768 khz clock on a pin.
// Function
// - ms alarm thousands digit is one bit at 12; bits 15-13 read zero.
// - ms alarm hundreds, tens, units digits at 11-8, 7-4, 3-0.
// - seconds count tens at 6-4, units at 3-0; bits 15-7 zero.
// - seconds alarm uses the seconds count layout.
// - minutes count tens at 6-4, units at 3-0; upper bits zero.
// - minutes alarm tens at 6-4, units at 3-0.
// - hours count tens at 5-4, units at 3-0, 24 hour; bits 15-6 zero.
// - hours alarm tens at 5-4, units at 3-0.
// - day count tens at 5-4, units at 3-0; bits 15-6 zero.
// - day alarm tens at 5-4, units at 3-0.
// - month count tens bit 4, units 3-0; bits 15-5 zero.
// - month alarm tens bit 4, units 3-0.
// - year count two bcd digits at 7-4 and 3-0; bits 15-8 zero.
// - year alarm two bcd digits at 7-4 and 3-0.
// - writes take effect on rtc clock edges; cpu clock at least 3x rtc.
// - time push bit 15 loads the counter, then reads zero.
// - alarm push bit 14 loads the alarm, then reads zero.
`timescale 1ns/1ps
module rtcb_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // rtc clock pin
  input wire logic i_rtc_clk,
  // cpu register port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // alarm event toward the flag logic
  output logic o_alarm_event
);
  import rtcb_pkg::*;

  localparam rtcb_time_s TIME_RST = '{RST_MS_HI, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                                      RST_DAY, RST_MONTH, RST_ZERO};
  // zero day never matches, so reset alone raises no alarm
  localparam rtcb_time_s ALARM_RST = '{RST_MS_HI, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                                       RST_ZERO, RST_ZERO, RST_ZERO};

  // store a write into the field set, masked to its implemented bits
  function automatic rtcb_time_s apply_wr(rtcb_time_s t, logic [15:0] base, logic [15:0] wd);
    rtcb_time_s r;
    r = t;
    case (base)
      ADDR_MS: begin
        r.ms_hi = wd[12:8] & MS_MASK[12:8];
        r.ms_lo = wd[7:0];
      end
      ADDR_SEC: r.sec = wd[7:0] & SEC_MASK[7:0];
      ADDR_MIN: r.min = wd[7:0] & MIN_MASK[7:0];
      ADDR_HOUR: r.hour = wd[7:0] & HOUR_MASK[7:0];
      ADDR_DAY: r.day = wd[7:0] & DAY_MASK[7:0];
      ADDR_MONTH: r.month = wd[7:0] & MONTH_MASK[7:0];
      ADDR_YEAR: r.year = wd[7:0] & YEAR_MASK[7:0];
      default: r = t;
    endcase
    return r;
  endfunction

  // present one field as a register word; reserved bits and holes read zero
  function automatic logic [15:0] rd_word(rtcb_time_s t, logic [15:0] base);
    case (base)
      ADDR_MS: return {3'h0, t.ms_hi, t.ms_lo} & MS_MASK;
      ADDR_SEC: return {8'h00, t.sec} & SEC_MASK;
      ADDR_MIN: return {8'h00, t.min} & MIN_MASK;
      ADDR_HOUR: return {8'h00, t.hour} & HOUR_MASK;
      ADDR_DAY: return {8'h00, t.day} & DAY_MASK;
      ADDR_MONTH: return {8'h00, t.month} & MONTH_MASK;
      ADDR_YEAR: return {8'h00, t.year} & YEAR_MASK;
      default: return 16'h0000;
    endcase
  endfunction

  logic [1:0] rst_pipe_q;
  logic rst_n;
  rtcb_time_s time_shadow_q;
  rtcb_time_s alarm_shadow_q;
  rtcb_time_s alarm_q;
  logic time_req_q;
  logic alarm_req_q;
  logic match_q;
  logic [15:0] even_addr;
  logic upd_wr;
  logic time_hit;

  rtcb_link_if lk ();

  assign rst_n = rst_pipe_q[1];
  assign even_addr = {i_addr[15:1], 1'b0};
  assign upd_wr = i_wr && i_addr == ADDR_UPDATE;
  assign time_hit = lk.cur == alarm_q;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  rtcb_tick u_tick (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_rtc_clk(i_rtc_clk),
    .lk(lk.tick_src)
  );

  rtcb_cal u_cal (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .lk(lk.cnt)
  );

  // staged values wait on the cpu side until a push moves them on an rtc edge
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      time_shadow_q <= TIME_RST;
    end else if (i_wr && !i_addr[0]) begin
      time_shadow_q <= apply_wr(time_shadow_q, i_addr, i_wdata);
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_shadow_q <= ALARM_RST;
    end else if (i_wr && i_addr[0]) begin
      alarm_shadow_q <= apply_wr(alarm_shadow_q, even_addr, i_wdata);
    end
  end

  // a new request in the completing cycle stays pending
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      time_req_q <= 1'b0;
    end else if (upd_wr && i_wdata[TIME_PUSH_BIT]) begin
      time_req_q <= 1'b1;
    end else if (time_req_q && lk.rtc_tick) begin
      time_req_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_req_q <= 1'b0;
    end else if (upd_wr && i_wdata[ALARM_PUSH_BIT]) begin
      alarm_req_q <= 1'b1;
    end else if (alarm_req_q && lk.rtc_tick) begin
      alarm_req_q <= 1'b0;
    end
  end

  assign lk.load = time_req_q && lk.rtc_tick;
  assign lk.load_val = time_shadow_q;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= ALARM_RST;
    end else if (alarm_req_q && lk.rtc_tick) begin
      alarm_q <= alarm_shadow_q;
    end
  end

  // count addresses read the live counter, alarm addresses the active alarm
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      if (i_addr == ADDR_UPDATE) begin
        o_rdata <= {time_req_q, alarm_req_q, 14'h0000};
      end else if (i_addr[0]) begin
        o_rdata <= rd_word(alarm_q, even_addr);
      end else begin
        o_rdata <= rd_word(lk.cur, i_addr);
      end
    end
  end

  // one pulse when the time first equals the alarm
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b0;
      o_alarm_event <= 1'b0;
    end else begin
      match_q <= time_hit;
      o_alarm_event <= time_hit && !match_q;
    end
  end

  property p_msa_rsv;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_MS + 16'h0001)) |=>
        o_rdata[15:13] == 3'h0 && o_rdata[12] == $past(alarm_q.ms_hi[4]);
  endproperty
  a_msa_rsv: assert property (p_msa_rsv) else $error("ms alarm thousands bad");

  property p_msa_digits;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_MS + 16'h0001)) |=>
        o_rdata[11:0] == {$past(alarm_q.ms_hi[3:0]), $past(alarm_q.ms_lo)};
  endproperty
  a_msa_digits: assert property (p_msa_digits) else $error("ms alarm digits bad");

  property p_sec_rsv;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == ADDR_SEC) |=> o_rdata[15:7] == 9'h000;
  endproperty
  a_sec_rsv: assert property (p_sec_rsv) else $error("seconds reserved bits set");

  property p_seca_layout;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_SEC + 16'h0001)) |=> o_rdata == {9'h000, $past(alarm_q.sec[6:0])};
  endproperty
  a_seca_layout: assert property (p_seca_layout) else $error("seconds alarm layout bad");

  property p_min_rsv;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == ADDR_MIN) |=> o_rdata[15:7] == 9'h000;
  endproperty
  a_min_rsv: assert property (p_min_rsv) else $error("minutes reserved bits set");

  property p_hour_rsv;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == ADDR_HOUR) |=> o_rdata[15:6] == 10'h000;
  endproperty
  a_hour_rsv: assert property (p_hour_rsv) else $error("hours reserved bits set");

  property p_month_rsv;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == ADDR_MONTH) |=> o_rdata[15:5] == 11'h000;
  endproperty
  a_month_rsv: assert property (p_month_rsv) else $error("month reserved bits set");

  property p_year_rsv;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == ADDR_YEAR) |=> o_rdata[15:8] == 8'h00;
  endproperty
  a_year_rsv: assert property (p_year_rsv) else $error("year reserved bits set");

  sequence s_time_push;
    time_req_q && lk.rtc_tick;
  endsequence

  sequence s_time_loaded;
    lk.load ##1 (lk.cur == $past(time_shadow_q));
  endsequence

  property p_time_push;
    @(posedge i_mclk) disable iff (!rst_n) s_time_push |-> s_time_loaded;
  endproperty
  a_time_push: assert property (p_time_push) else $error("time push did not load");

  property p_time_done;
    @(posedge i_mclk) disable iff (!rst_n)
      (s_time_push and !(upd_wr && i_wdata[TIME_PUSH_BIT])) |=> !time_req_q;
  endproperty
  a_time_done: assert property (p_time_done) else $error("time push bit stuck");

  property p_alarm_push;
    @(posedge i_mclk) disable iff (!rst_n)
      (alarm_req_q && lk.rtc_tick) |=> alarm_q == $past(alarm_shadow_q);
  endproperty
  a_alarm_push: assert property (p_alarm_push) else $error("alarm push did not load");

  property p_load_on_edge;
    @(posedge i_mclk) disable iff (!rst_n)
      lk.load |-> lk.rtc_tick && ($past(time_req_q) || $past(upd_wr && i_wdata[TIME_PUSH_BIT]));
  endproperty
  a_load_on_edge: assert property (p_load_on_edge) else $error("load off rtc edge");

  property p_alarm_event;
    @(posedge i_mclk) disable iff (!rst_n)
      (time_hit && !match_q) |=> o_alarm_event ##1 !o_alarm_event;
  endproperty
  a_alarm_event: assert property (p_alarm_event) else $error("alarm event missing");

  property p_day_rsv;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == ADDR_DAY) |=> o_rdata[15:6] == 10'h000;
  endproperty
  a_day_rsv: assert property (p_day_rsv) else $error("day reserved bits set");

  property p_mina_layout;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_MIN + 16'h0001)) |=>
        o_rdata == {9'h000, $past(alarm_q.min[6:0])};
  endproperty
  a_mina_layout: assert property (p_mina_layout) else $error("minutes alarm layout bad");

  property p_houra_layout;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_HOUR + 16'h0001)) |=>
        o_rdata == {10'h000, $past(alarm_q.hour[5:0])};
  endproperty
  a_houra_layout: assert property (p_houra_layout) else $error("hours alarm layout bad");

  property p_daya_layout;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_DAY + 16'h0001)) |=>
        o_rdata == {10'h000, $past(alarm_q.day[5:0])};
  endproperty
  a_daya_layout: assert property (p_daya_layout) else $error("day alarm layout bad");

  property p_montha_layout;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_MONTH + 16'h0001)) |=>
        o_rdata == {11'h000, $past(alarm_q.month[4:0])};
  endproperty
  a_montha_layout: assert property (p_montha_layout) else $error("month alarm layout bad");

  property p_yeara_layout;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == (ADDR_YEAR + 16'h0001)) |=>
        o_rdata == {8'h00, $past(alarm_q.year)};
  endproperty
  a_yeara_layout: assert property (p_yeara_layout) else $error("year alarm layout bad");

  // count writes reach the counter only through a push on an rtc edge
  property p_time_hold;
    @(posedge i_mclk) disable iff (!rst_n)
      (!lk.load && !lk.ms_tick) |=> $stable(lk.cur);
  endproperty
  a_time_hold: assert property (p_time_hold) else $error("counter moved off a tick");

  property p_alarm_hold;
    @(posedge i_mclk) disable iff (!rst_n)
      !(alarm_req_q && lk.rtc_tick) |=> $stable(alarm_q);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm moved without push");

  property p_upd_rd;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_rd && i_addr == ADDR_UPDATE) |=>
        o_rdata == {$past(time_req_q), $past(alarm_req_q), 14'h0000};
  endproperty
  a_upd_rd: assert property (p_upd_rd) else $error("update register read bad");

  property p_event_cause;
    @(posedge i_mclk) disable iff (!rst_n)
      o_alarm_event |-> $past(lk.cur == alarm_q) && !$past(match_q);
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("alarm event without match");

  property p_event_once;
    @(posedge i_mclk) disable iff (!rst_n)
      o_alarm_event |=> !o_alarm_event;
  endproperty
  a_event_once: assert property (p_event_once) else $error("alarm event too long");

endmodule

// ==== logic/rtcb_pkg.sv ====
// rtcb_pkg: register map, field masks, reset values and timing constants
// of the bcd time and alarm block; shared by every rtcb module.
package rtcb_pkg;

  // one time or alarm set, each field packed bcd, thousands digit of ms in ms_hi[4]
  typedef struct packed {
    logic [4:0] ms_hi;
    logic [7:0] ms_lo;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
  } rtcb_time_s;

  // cpu word addresses; each alarm register sits one above its count
  localparam logic [15:0] ADDR_UPDATE = 16'h1901;
  localparam logic [15:0] ADDR_MS = 16'h1904;
  localparam logic [15:0] ADDR_SEC = 16'h1908;
  localparam logic [15:0] ADDR_MIN = 16'h190C;
  localparam logic [15:0] ADDR_HOUR = 16'h1910;
  localparam logic [15:0] ADDR_DAY = 16'h1914;
  localparam logic [15:0] ADDR_MONTH = 16'h1918;
  localparam logic [15:0] ADDR_YEAR = 16'h191C;

  // update register bit positions
  localparam int TIME_PUSH_BIT = 15;
  localparam int ALARM_PUSH_BIT = 14;

  // implemented bits of each register; all others read zero
  localparam logic [15:0] MS_MASK = 16'h1FFF;
  localparam logic [15:0] SEC_MASK = 16'h007F;
  localparam logic [15:0] MIN_MASK = 16'h007F;
  localparam logic [15:0] HOUR_MASK = 16'h003F;
  localparam logic [15:0] DAY_MASK = 16'h003F;
  localparam logic [15:0] MONTH_MASK = 16'h001F;
  localparam logic [15:0] YEAR_MASK = 16'h00FF;

  // reset values
  localparam logic [4:0] RST_MS_HI = 5'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;

  // counting limits, bcd
  localparam logic [7:0] LAST_SEC = 8'h59;
  localparam logic [7:0] LAST_HOUR = 8'h23;
  localparam logic [7:0] LAST_MONTH = 8'h12;
  localparam logic [7:0] LAST_PAIR = 8'h99;
  localparam logic [7:0] FIRST_ONE = 8'h01;
  localparam logic [3:0] LAST_DIGIT = 4'h9;

  // millisecond generation from the 32.768 khz clock
  localparam int RTC_CLK_HZ = 32768;
  localparam int MS_PER_SEC = 1000;

endpackage

// ==== logic/rtcb_link_if.sv ====
// rtcb_link_if: ticks, counter load and live time between the rtcb modules.
// assumes all three modules share one clock.
`timescale 1ns/1ps
interface rtcb_link_if;
  import rtcb_pkg::*;
  logic rtc_tick;
  logic ms_tick;
  logic load;
  rtcb_time_s load_val;
  rtcb_time_s cur;
  modport tick_src (output rtc_tick, output ms_tick);
  modport cnt (input ms_tick, input load, input load_val, output cur);
  modport ctl (input rtc_tick, input ms_tick, input cur, output load, output load_val);
endinterface

// ==== logic/rtcb_tick.sv ====
// rtcb_tick: samples the 32.768 khz pin and makes rtc and millisecond ticks.
// assumes the system clock is at least three times the pin rate.
`timescale 1ns/1ps
module rtcb_tick (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // rtc clock pin
  input wire logic i_rtc_clk,
  // ticks
  rtcb_link_if.tick_src lk
);
  import rtcb_pkg::*;

  localparam logic [16:0] ACC_STEP = 17'(MS_PER_SEC);
  localparam logic [16:0] ACC_WRAP = 17'(RTC_CLK_HZ);

  logic [2:0] sync_q;
  logic level_q;
  logic [16:0] acc_q;
  logic [16:0] acc_sum;

  assign acc_sum = acc_q + ACC_STEP;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], i_rtc_clk};
      if (sync_q[1] == sync_q[2]) begin
        level_q <= sync_q[2];
      end
    end
  end

  // fractional accumulator: exactly 1000 ms ticks per 32768 rtc edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk.rtc_tick <= 1'b0;
      lk.ms_tick <= 1'b0;
      acc_q <= 17'h00000;
    end else begin
      lk.rtc_tick <= sync_q[1] & sync_q[2] & ~level_q;
      lk.ms_tick <= 1'b0;
      if (sync_q[1] & sync_q[2] & ~level_q) begin
        if (acc_sum >= ACC_WRAP) begin
          acc_q <= acc_sum - ACC_WRAP;
          lk.ms_tick <= 1'b1;
        end else begin
          acc_q <= acc_sum;
        end
      end
    end
  end

  property p_ms_on_rtc;
    @(posedge i_clk) disable iff (!i_rst_n) lk.ms_tick |-> lk.rtc_tick;
  endproperty
  a_ms_on_rtc: assert property (p_ms_on_rtc) else $error("ms tick without rtc tick");

endmodule

// ==== logic/rtcb_cal.sv ====
// rtcb_cal: cascaded bcd calendar counter, ms up to years of the 2000s.
// assumes load and ms_tick come from the same clock; load wins.
`timescale 1ns/1ps
module rtcb_cal (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // ticks, load and live time
  rtcb_link_if.cnt lk
);
  import rtcb_pkg::*;

  // {carry, next} of a two digit bcd value that wraps from last to first
  function automatic logic [8:0] bcd2_next(logic [7:0] v, logic [7:0] last, logic [7:0] first);
    if (v >= last) begin
      return {1'b1, first};
    end
    if (v[3:0] >= LAST_DIGIT) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] days_last(logic [7:0] month, logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6) :
                     (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (month)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  rtcb_time_s nxt;

  always_comb begin
    logic [8:0] r;
    logic c;
    r = 9'h000;
    c = 1'b0;
    nxt = lk.cur;
    r = bcd2_next(lk.cur.ms_lo, LAST_PAIR, RST_ZERO);
    nxt.ms_lo = r[7:0];
    if (r[8]) begin
      if (lk.cur.ms_hi[4] || lk.cur.ms_hi[3:0] >= LAST_DIGIT) begin
        nxt.ms_hi = RST_MS_HI;
        c = 1'b1;
      end else begin
        nxt.ms_hi = {1'b0, lk.cur.ms_hi[3:0] + 4'h1};
      end
    end
    if (c) begin
      r = bcd2_next(lk.cur.sec, LAST_SEC, RST_ZERO);
      nxt.sec = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd2_next(lk.cur.min, LAST_SEC, RST_ZERO);
      nxt.min = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd2_next(lk.cur.hour, LAST_HOUR, RST_ZERO);
      nxt.hour = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd2_next(lk.cur.day, days_last(lk.cur.month, lk.cur.year), FIRST_ONE);
      nxt.day = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd2_next(lk.cur.month, LAST_MONTH, FIRST_ONE);
      nxt.month = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd2_next(lk.cur.year, LAST_PAIR, RST_ZERO);
      nxt.year = r[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk.cur <= '{RST_MS_HI, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_DAY, RST_MONTH,
                  RST_ZERO};
    end else if (lk.load) begin
      lk.cur <= lk.load_val;
    end else if (lk.ms_tick) begin
      lk.cur <= nxt;
    end
  end

  sequence s_last_ms_of_minute;
    lk.ms_tick && !lk.load && lk.cur.ms_lo == LAST_PAIR && lk.cur.ms_hi == 5'h09 &&
      lk.cur.sec == LAST_SEC;
  endsequence

  property p_minute_carry;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_last_ms_of_minute |=> lk.cur.sec == RST_ZERO && lk.cur.ms_lo == RST_ZERO &&
        lk.cur.min != $past(lk.cur.min);
  endproperty
  a_minute_carry: assert property (p_minute_carry) else $error("no carry into minutes");

endmodule

// ==== verification/rtcb_tb.sv ====
// rtcb_tb: self-checking bench for the bcd time and alarm registers.
// assumes rtcb_top with its package; drives the cpu port and the rtc pin itself.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  import rtcb_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_rtc_clk = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] o_rdata;
  logic o_alarm_event;
  int num_errors = 0;
  int n_tests = 0;
  int n_alarm = 0;
  logic [15:0] v;
  logic [15:0] cnt_addr [7];
  logic [15:0] rst_cnt [7];
  logic [15:0] load_val [7];
  logic [15:0] load_exp [7];
  logic [15:0] wrap_exp [7];
  logic [15:0] alarm_val [7];

  rtcb_top dut (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_rtc_clk(i_rtc_clk),
    .i_addr(i_addr),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_alarm_event(o_alarm_event)
  );

  initial begin
    forever #10 i_mclk = ~i_mclk;
  end

  // about 32.768 khz: 1526 system cycles per period, phase unrelated to the cpu port
  initial begin
    forever begin
      repeat (763) @(negedge i_mclk);
      i_rtc_clk = ~i_rtc_clk;
    end
  end

  always @(posedge i_mclk) begin
    if (o_alarm_event === 1'b1) begin
      n_alarm++;
    end
  end

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(negedge i_mclk);
    i_addr = addr;
    i_wdata = data;
    i_wr = 1'b1;
    @(negedge i_mclk);
    i_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] addr, output logic [15:0] data);
    @(negedge i_mclk);
    i_addr = addr;
    i_rd = 1'b1;
    @(negedge i_mclk);
    i_rd = 1'b0;
    @(negedge i_mclk);
    data = o_rdata;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // polls the update register until the pushed bits have cleared
  task automatic wait_push_done();
    int i;
    for (i = 0; i < 4000; i++) begin
      rd(ADDR_UPDATE, v);
      if (v === 16'h0000) begin
        break;
      end
    end
    if (i == 4000) begin
      num_errors++;
      $display("wrong value at %0t: push never completed", $time);
      end_of_test();
    end
  endtask

  task automatic write_alarms(input logic [15:0] val [7]);
    for (int k = 0; k < 7; k++) begin
      wr(cnt_addr[k] + 16'h0001, val[k]);
    end
    wr(ADDR_UPDATE, 16'h4000);
    wait_push_done();
  endtask

  initial begin
    int i;
    cnt_addr = '{ADDR_MS, ADDR_SEC, ADDR_MIN, ADDR_HOUR, ADDR_DAY, ADDR_MONTH, ADDR_YEAR};
    rst_cnt = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
    load_val = '{16'hE999, 16'hFF59, 16'hFF59, 16'hFFE3, 16'hFFF1, 16'hFFF2, 16'hFF99};
    load_exp = '{16'h0999, 16'h0059, 16'h0059, 16'h0023, 16'h0031, 16'h0012, 16'h0099};
    wrap_exp = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
    alarm_val = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
    repeat (12) @(negedge i_mclk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_mclk);

    // reset state of counts, alarms, update register and an unmapped place
    for (int k = 0; k < 7; k++) begin
      rd(cnt_addr[k], v);
      `CHK(v, rst_cnt[k])
      rd(cnt_addr[k] + 16'h0001, v);
      `CHK(v, 16'h0000)
    end
    rd(ADDR_UPDATE, v);
    `CHK(v, 16'h0000)
    wr(16'h1906, 16'hFFFF);
    rd(16'h1906, v);
    `CHK(v, 16'h0000)
    $display("test reset values done");

    // alarm fields written all ones keep only their documented bits
    write_alarms('{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    rd(cnt_addr[0] + 16'h0001, v);
    `CHK(v, MS_MASK)
    rd(cnt_addr[0] + 16'h0001, v);
    `CHK(v[11:0], 12'hFFF)
    rd(cnt_addr[1] + 16'h0001, v);
    `CHK(v, 16'h007F)
    rd(cnt_addr[2] + 16'h0001, v);
    `CHK(v, 16'h007F)
    rd(cnt_addr[3] + 16'h0001, v);
    `CHK(v, 16'h003F)
    rd(cnt_addr[4] + 16'h0001, v);
    `CHK(v, 16'h003F)
    rd(cnt_addr[5] + 16'h0001, v);
    `CHK(v, 16'h001F)
    rd(cnt_addr[6] + 16'h0001, v);
    `CHK(v, 16'h00FF)
    $display("test alarm layout done");

    // alarm and time staged together, one push lands both: reset time never meets the alarm
    for (int k = 0; k < 7; k++) begin
      wr(cnt_addr[k] + 16'h0001, alarm_val[k]);
      wr(cnt_addr[k], load_val[k]);
    end
    rd(ADDR_SEC, v);
    `CHK(v, 16'h0000)
    rd(ADDR_SEC + 16'h0001, v);
    `CHK(v, 16'h007F)
    wr(ADDR_UPDATE, 16'hC000);
    rd(ADDR_UPDATE, v);
    `CHK(v, 16'hC000)
    wait_push_done();
    for (int k = 0; k < 7; k++) begin
      rd(cnt_addr[k] + 16'h0001, v);
      `CHK(v, alarm_val[k])
    end
    $display("test alarm push done");
    rd(ADDR_MS, v);
    `CHK(v, load_exp[0])
    rd(ADDR_SEC, v);
    `CHK(v, load_exp[1])
    rd(ADDR_MIN, v);
    `CHK(v, load_exp[2])
    rd(ADDR_HOUR, v);
    `CHK(v, load_exp[3])
    rd(ADDR_DAY, v);
    `CHK(v, load_exp[4])
    rd(ADDR_MONTH, v);
    `CHK(v, load_exp[5])
    rd(ADDR_YEAR, v);
    `CHK(v, load_exp[6])
    `CHK(n_alarm, 0)
    $display("test time push done");

    // one millisecond later every field carries over to the next century
    for (i = 0; i < 20000; i++) begin
      rd(ADDR_YEAR, v);
      if (v === 16'h0000) begin
        break;
      end
    end
    if (i == 20000) begin
      num_errors++;
      $display("wrong value at %0t: no carry into the year", $time);
      end_of_test();
    end
    for (int k = 0; k < 7; k++) begin
      rd(cnt_addr[k], v);
      `CHK(v, wrap_exp[k])
    end
    repeat (100) @(negedge i_mclk);
    `CHK(n_alarm, 1)
    $display("test carry and alarm done");
    end_of_test();
  end
endmodule
